// ==== rtl/dscp_host.v ====
/*
 * Host controller for the dual serial control port of an audio receiver.
 * It takes single register writes and burst reads at a user port and runs
 * them over the four-wire or the two-wire protocol on the device pins.
 * Assumes the protocol select and address straps are static, and that the
 * pin wires are resolved from the output enables outside this module.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dscp_map.vh"

module dscp_host (
    input wire i_core_clk,
    input wire i_rstn,
    input wire i_use_i2c,
    input wire [2:0] i_i2c_strap,
    input wire i_cmd_valid,
    input wire i_cmd_write,
    input wire [6:0] i_cmd_reg,
    input wire [7:0] i_cmd_wdata,
    input wire [2:0] i_cmd_len,
    output reg o_cmd_ready,
    output reg o_rd_valid,
    output reg [7:0] o_rd_data,
    output reg o_rd_last,
    output reg o_done,
    output reg o_nack,
    output reg o_ctrl_bit_clock_out,
    output reg o_ctrl_bit_clock_oe,
    input wire i_ctrl_serial_in_in,
    output reg o_ctrl_serial_in_out,
    output reg o_ctrl_serial_in_oe,
    input wire i_ctrl_serial_out,
    output reg o_addr0_or_select_pin_out,
    output reg o_addr0_or_select_pin_oe
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_START = 3'h1;
    localparam [2:0] ST_BIT = 3'h2;
    localparam [2:0] ST_ACK = 3'h3;
    localparam [2:0] ST_STOP = 3'h4;
    localparam [2:0] ST_GAP = 3'h5;

    // Byte to send at position idx of a frame; frame 1 is the read frame.
    function [7:0] tx_byte;
        input frame;
        input [3:0] idx;
        input [6:0] reg_sel;
        input [7:0] wdata;
        input i2c;
        input [2:0] strap;
        reg [6:0] chip;
        begin
            chip = i2c ? {`DSCP_I2C_ADDR_HI, strap} : `DSCP_SPI_CHIP_ADDR;
            if (idx == 4'h0) begin
                tx_byte = {chip, frame ? `DSCP_DIR_READ : `DSCP_DIR_WRITE};
            end else if (frame) begin
                tx_byte = `DSCP_IDLE_BYTE;
            end else if (idx == 4'h1) begin
                tx_byte = {1'b0, reg_sel};
            end else begin
                tx_byte = wdata;
            end
        end
    endfunction

    reg cap_q;
    reg mode_q;
    reg [2:0] strap_q;
    reg sdi_meta_q;
    reg sdi_sync_q;
    reg sdo_meta_q;
    reg sdo_sync_q;
    reg [2:0] state_q, state_d;
    reg [1:0] qtr_q, qtr_d;
    reg [2:0] bit_q, bit_d;
    reg [3:0] idx_q, idx_d;
    reg frame_q, frame_d;
    reg [7:0] shift_q, shift_d;
    reg ackin_q, ackin_d;
    reg err_q, err_d;
    reg wr_q, wr_d;
    reg [6:0] reg_q, reg_d;
    reg [7:0] wdata_q, wdata_d;
    reg [2:0] len_q, len_d;
    reg scl_q, scl_d;
    reg sda_q, sda_d;
    reg sel_q, sel_d;
    reg run_q, run_d;
    reg ready_d, rdv_d, rdl_d, done_d, nack_d;
    reg [7:0] rdd_d;
    reg fin;
    wire tick;
    wire line_in;
    wire rx_byte;
    wire last_byte;
    wire [3:0] last_idx;

    dscp_tick u_tick (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_run(run_q),
        .o_tick(tick)
    );

    // Protocol and straps are caught once, just after reset release.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cap_q <= 1'b0;
            mode_q <= 1'b0;
            strap_q <= 3'h0;
        end else if (!cap_q) begin
            cap_q <= 1'b1;
            mode_q <= i_use_i2c;
            strap_q <= i_i2c_strap;
        end
    end

    // Pin inputs cross into the core clock through two flip-flops each.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sdi_meta_q <= 1'b1;
            sdi_sync_q <= 1'b1;
            sdo_meta_q <= 1'b1;
            sdo_sync_q <= 1'b1;
        end else begin
            sdi_meta_q <= i_ctrl_serial_in_in;
            sdi_sync_q <= sdi_meta_q;
            sdo_meta_q <= i_ctrl_serial_out;
            sdo_sync_q <= sdo_meta_q;
        end
    end

    // The data line is the shared wire in I2C and the device output otherwise.
    assign line_in = mode_q ? sdi_sync_q : sdo_sync_q;
    assign rx_byte = frame_q & (idx_q != 4'h0);
    assign last_idx = frame_q ? ({1'b0, len_q} + 4'h1) : (wr_q ? 4'h2 : 4'h1);
    assign last_byte = (idx_q == last_idx);

    // Transfer sequencer: each bit is four quarter ticks.
    always @* begin
        state_d = state_q;
        qtr_d = qtr_q;
        bit_d = bit_q;
        idx_d = idx_q;
        frame_d = frame_q;
        shift_d = shift_q;
        ackin_d = ackin_q;
        err_d = err_q;
        wr_d = wr_q;
        reg_d = reg_q;
        wdata_d = wdata_q;
        len_d = len_q;
        scl_d = scl_q;
        sda_d = sda_q;
        sel_d = sel_q;
        run_d = run_q;
        ready_d = o_cmd_ready;
        rdv_d = 1'b0;
        rdd_d = o_rd_data;
        rdl_d = o_rd_last;
        done_d = 1'b0;
        nack_d = o_nack;
        fin = 1'b0;
        if (tick) begin
            qtr_d = qtr_q + 2'h1;
        end
        case (state_q)
            ST_IDLE: begin
                // Pins are left untouched until a command arrives.
                if (!o_cmd_ready) begin
                    ready_d = cap_q;
                end else if (i_cmd_valid) begin
                    wr_d = i_cmd_write;
                    reg_d = i_cmd_reg;
                    wdata_d = i_cmd_wdata;
                    len_d = i_cmd_write ? 3'h0 : i_cmd_len;
                    ready_d = 1'b0;
                    run_d = 1'b1;
                    state_d = ST_START;
                    qtr_d = 2'h0;
                    frame_d = 1'b0;
                    idx_d = 4'h0;
                    err_d = 1'b0;
                end
            end
            ST_START: begin
                if (tick) begin
                    if (mode_q) begin
                        if (qtr_q == 2'h0) begin
                            sda_d = 1'b1;
                            scl_d = 1'b1;
                        end
                        if (qtr_q == 2'h1) begin
                            sda_d = 1'b0;
                        end
                        if (qtr_q == 2'h3) begin
                            scl_d = 1'b0;
                        end
                    end else if (qtr_q == 2'h0) begin
                        sel_d = 1'b0;
                    end
                    if (qtr_q == 2'h3) begin
                        state_d = ST_BIT;
                        bit_d = 3'h0;
                        shift_d = tx_byte(frame_q, idx_q, reg_q, wdata_q, mode_q,
                            strap_q);
                    end
                end
            end
            ST_BIT: begin
                if (tick) begin
                    if (mode_q) begin
                        if (qtr_q == 2'h0) begin
                            sda_d = rx_byte | shift_q[7];
                        end
                        if (qtr_q == 2'h1) begin
                            scl_d = 1'b1;
                        end
                        if (qtr_q == 2'h3) begin
                            scl_d = 1'b0;
                        end
                    end else begin
                        if (qtr_q == 2'h0) begin
                            scl_d = 1'b0;
                            sda_d = shift_q[7];
                        end
                        if (qtr_q == 2'h2) begin
                            scl_d = 1'b1;
                        end
                    end
                    if (qtr_q == 2'h2) begin
                        shift_d = {shift_q[6:0], line_in};
                    end
                    if (qtr_q == 2'h3) begin
                        if (bit_q == 3'h7) begin
                            if (mode_q) begin
                                state_d = ST_ACK;
                            end else begin
                                fin = 1'b1;
                            end
                        end else begin
                            bit_d = bit_q + 3'h1;
                        end
                    end
                end
            end
            ST_ACK: begin
                if (tick) begin
                    if (qtr_q == 2'h0) begin
                        sda_d = rx_byte ? last_byte : 1'b1;
                    end
                    if (qtr_q == 2'h1) begin
                        scl_d = 1'b1;
                    end
                    if (qtr_q == 2'h2) begin
                        ackin_d = line_in;
                    end
                    if (qtr_q == 2'h3) begin
                        scl_d = 1'b0;
                        fin = 1'b1;
                    end
                end
            end
            ST_STOP: begin
                if (tick) begin
                    if (mode_q) begin
                        if (qtr_q == 2'h0) begin
                            sda_d = 1'b0;
                        end
                        if (qtr_q == 2'h1) begin
                            scl_d = 1'b1;
                        end
                        if (qtr_q == 2'h2) begin
                            sda_d = 1'b1;
                        end
                    end else if (qtr_q == 2'h0) begin
                        sel_d = 1'b1;
                    end
                    if (qtr_q == 2'h3) begin
                        state_d = ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                // One idle bit between frames; then the read frame or the end.
                if (tick && qtr_q == 2'h3) begin
                    if (!frame_q && !wr_q && !err_q) begin
                        frame_d = 1'b1;
                        idx_d = 4'h0;
                        state_d = ST_START;
                    end else begin
                        state_d = ST_IDLE;
                        run_d = 1'b0;
                        ready_d = 1'b1;
                        done_d = 1'b1;
                        nack_d = err_q;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // End of a byte: hand up read data, stop on refusal or after the last byte, or go on.
        if (fin) begin
            if (rx_byte) begin
                rdv_d = 1'b1;
                rdd_d = shift_q;
                rdl_d = last_byte;
            end
            if (!rx_byte && mode_q && ackin_q) begin
                err_d = 1'b1;
                state_d = ST_STOP;
            end else if (last_byte) begin
                state_d = ST_STOP;
            end else begin
                idx_d = idx_q + 4'h1;
                bit_d = 3'h0;
                state_d = ST_BIT;
                shift_d = tx_byte(frame_q, idx_q + 4'h1, reg_q, wdata_q, mode_q, strap_q);
            end
        end
    end

    // Sequencer state and user-side answers.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q <= ST_IDLE;
            qtr_q <= 2'h0;
            bit_q <= 3'h0;
            idx_q <= 4'h0;
            frame_q <= 1'b0;
            shift_q <= 8'h00;
            ackin_q <= 1'b0;
            err_q <= 1'b0;
            wr_q <= 1'b0;
            reg_q <= 7'h00;
            wdata_q <= 8'h00;
            len_q <= 3'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            sel_q <= 1'b1;
            run_q <= 1'b0;
            o_cmd_ready <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            o_rd_last <= 1'b0;
            o_done <= 1'b0;
            o_nack <= 1'b0;
        end else begin
            state_q <= state_d;
            qtr_q <= qtr_d;
            bit_q <= bit_d;
            idx_q <= idx_d;
            frame_q <= frame_d;
            shift_q <= shift_d;
            ackin_q <= ackin_d;
            err_q <= err_d;
            wr_q <= wr_d;
            reg_q <= reg_d;
            wdata_q <= wdata_d;
            len_q <= len_d;
            scl_q <= scl_d;
            sda_q <= sda_d;
            sel_q <= sel_d;
            run_q <= run_d;
            o_cmd_ready <= ready_d;
            o_rd_valid <= rdv_d;
            o_rd_data <= rdd_d;
            o_rd_last <= rdl_d;
            o_done <= done_d;
            o_nack <= nack_d;
        end
    end

    // Pin drivers: open drain in I2C, push-pull otherwise; all released
    // until the mode is known, and the select pin is never driven in I2C so
    // that its strap stays static.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ctrl_bit_clock_out <= 1'b0;
            o_ctrl_bit_clock_oe <= 1'b0;
            o_ctrl_serial_in_out <= 1'b0;
            o_ctrl_serial_in_oe <= 1'b0;
            o_addr0_or_select_pin_out <= 1'b1;
            o_addr0_or_select_pin_oe <= 1'b0;
        end else begin
            o_ctrl_bit_clock_out <= mode_q ? 1'b0 : scl_d;
            o_ctrl_bit_clock_oe <= cap_q & (mode_q ? ~scl_d : 1'b1);
            o_ctrl_serial_in_out <= mode_q ? 1'b0 : sda_d;
            o_ctrl_serial_in_oe <= cap_q & (mode_q ? ~sda_d : 1'b1);
            o_addr0_or_select_pin_out <= sel_d;
            o_addr0_or_select_pin_oe <= cap_q & ~mode_q;
        end
    end
endmodule // dscp_host

`default_nettype wire

// ==== rtl/dscp_map.vh ====
/*
 * Constants of the dual serial control port host: the device register map,
 * chip address fields and the bit timing of the host-made control clock.
 * Assumes a 10 MHz core clock and is included by its bare name.
 */
`ifndef DSCP_MAP_VH
`define DSCP_MAP_VH

// Core clock rate in MHz.
`define DSCP_CLK_MHZ 10
// Least quarter period of a control bit in ns, and its cycle count rounded up.
`define DSCP_QTR_NS 1000
`define DSCP_QTR_CYC ((`DSCP_QTR_NS * `DSCP_CLK_MHZ + 999) / 1000)

// Chip address of the four-wire protocol and fixed upper bits for I2C.
`define DSCP_SPI_CHIP_ADDR 7'h10
`define DSCP_I2C_ADDR_HI 4'h2
// Direction bit values in the address byte.
`define DSCP_DIR_WRITE 1'b0
`define DSCP_DIR_READ 1'b1
// Filler sent while the host only listens.
`define DSCP_IDLE_BYTE 8'hff

// Device register offsets (read only).
`define DSCP_REG_RECEIVED_STATUS_SUMMARY 7'h0a
`define DSCP_REG_SUBCODE_BYTE_0 7'h0e
`define DSCP_REG_SUBCODE_BYTE_9 7'h17
`define DSCP_REG_LEFT_STATUS_BYTE_0 7'h19
`define DSCP_REG_LEFT_STATUS_BYTE_4 7'h1d
`define DSCP_REG_RIGHT_STATUS_BYTE_0 7'h1e
`define DSCP_REG_RIGHT_STATUS_BYTE_4 7'h22
// Auxiliary bit count field of the received status summary.
`define DSCP_AUX_COUNT_MSB 7
`define DSCP_AUX_COUNT_LSB 4

`endif

// ==== rtl/dscp_tick.v ====
/*
 * Quarter-bit tick generator for the control port host.
 * Assumes the core clock; the count restarts whenever i_run is low.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dscp_map.vh"

module dscp_tick (
    input wire i_core_clk,
    input wire i_rstn,
    input wire i_run,
    output reg o_tick
);
    localparam integer LAST_I = `DSCP_QTR_CYC - 1;
    localparam [7:0] LAST = LAST_I[7:0];

    reg [7:0] cnt_q;

    // Counts quarter periods and pulses the tick for one cycle at each end.
    always @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_q <= 8'h00;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_q <= 8'h00;
            o_tick <= 1'b0;
        end else if (cnt_q == LAST) begin
            cnt_q <= 8'h00;
            o_tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h01;
            o_tick <= 1'b0;
        end
    end
endmodule // dscp_tick

`default_nettype wire

// ==== verification/dscp_host_checker.sv ====
/* Assertion checker bound to the ports of dscp_host.
   Assumes the pin wires are resolved from the enables outside the host. */
`timescale 1ns/100ps
`default_nettype none
module dscp_host_checker (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_use_i2c,
    input wire logic i_cmd_valid,
    input wire logic o_cmd_ready,
    input wire logic o_rd_valid,
    input wire logic o_rd_last,
    input wire logic o_done,
    input wire logic o_nack,
    input wire logic o_ctrl_bit_clock_out,
    input wire logic o_ctrl_bit_clock_oe,
    input wire logic o_ctrl_serial_in_out,
    input wire logic o_ctrl_serial_in_oe,
    input wire logic o_addr0_or_select_pin_out,
    input wire logic o_addr0_or_select_pin_oe
);
    // Open-drain pulls of the two-wire lines and the active select.
    wire sda_pull = o_ctrl_serial_in_oe & ~o_ctrl_serial_in_out;
    wire scl_pull = o_ctrl_bit_clock_oe & ~o_ctrl_bit_clock_out;
    wire sel_low = o_addr0_or_select_pin_oe & ~o_addr0_or_select_pin_out;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    property p_idle;
        o_cmd_ready && !i_cmd_valid |=> $stable({o_ctrl_bit_clock_out, o_ctrl_serial_in_out,
            o_ctrl_serial_in_oe, o_addr0_or_select_pin_out});
    endproperty
    a_idle: assert property (p_idle) else $error("pins moved while idle");
    property p_sel_busy;
        sel_low |-> !o_cmd_ready;
    endproperty
    a_sel_busy: assert property (p_sel_busy) else $error("select low while idle");
    property p_take_sel;
        i_cmd_valid && o_cmd_ready && !i_use_i2c |-> ##[1:40] sel_low;
    endproperty
    a_take_sel: assert property (p_take_sel) else $error("select did not fall");
    property p_sel_clk;
        $rose(sel_low) |-> o_ctrl_bit_clock_out;
    endproperty
    a_sel_clk: assert property (p_sel_clk) else $error("clock low at select fall");
    property p_spi_data;
        sel_low && $past(sel_low) && $changed(o_ctrl_serial_in_out) |-> !o_ctrl_bit_clock_out;
    endproperty
    a_spi_data: assert property (p_spi_data) else $error("data moved with clock high");
    property p_i2c_nosel;
        i_use_i2c |-> !o_addr0_or_select_pin_oe;
    endproperty
    a_i2c_nosel: assert property (p_i2c_nosel) else $error("select driven in I2C");
    property p_i2c_start;
        i_use_i2c && $rose(sda_pull) && !scl_pull |-> ##[1:30] scl_pull;
    endproperty
    a_i2c_start: assert property (p_i2c_start) else $error("no clock after start");
    property p_i2c_stop;
        i_use_i2c && $fell(sda_pull) && !scl_pull |-> ##[1:80] (o_done || sda_pull && !scl_pull);
    endproperty
    a_i2c_stop: assert property (p_i2c_stop) else $error("no done or start after stop");
    property p_last_done;
        o_rd_valid && o_rd_last |-> ##[1:200] o_done;
    endproperty
    a_last_done: assert property (p_last_done) else $error("no done after last byte");
endmodule // dscp_host_checker

bind dscp_host dscp_host_checker u_chk (.i_core_clk, .i_rstn, .i_use_i2c, .i_cmd_valid,
    .o_cmd_ready, .o_rd_valid, .o_rd_last, .o_done, .o_nack, .o_ctrl_bit_clock_out,
    .o_ctrl_bit_clock_oe, .o_ctrl_serial_in_out, .o_ctrl_serial_in_oe,
    .o_addr0_or_select_pin_out, .o_addr0_or_select_pin_oe);
`default_nettype wire

// ==== verification/dscp_dev_model.sv ====
/* Behavioural model of the receiver control port: map, four-wire and I2C slave.
   Assumes the bench resolves the wires with pull-ups. */
`timescale 1ns/100ps
`default_nettype none
module dscp_dev_model (
    input wire logic i_rstn,
    input wire logic [2:0] i_strap,
    input wire logic i_clk_w,
    input wire logic i_dat_w,
    input wire logic i_sel_w,
    output logic o_pull,
    output logic o_dout
);
    logic [7:0] mem [0:127];
    logic [7:0] sh, tsh;
    logic [6:0] ptr;
    logic [2:0] strap_q;
    logic [3:0] bn;
    int nb;
    logic spi, on, skip, rd, tx, drv, ok, last;
    // Fixed register contents, independent of any audio clock.
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'h5a ^ 8'(i);
        end
        {spi, on, skip, tx, drv, o_pull, last} = '0;
    end
    // Stores only into the writable control range.
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (a < 7'h0a) mem[a] = d;
    endtask
    // Straps sensed while reset is held.
    always @(i_rstn or i_strap) if (!i_rstn) begin
        strap_q = i_strap;
        spi = 0;
    end
    // Select falling after reset picks four-wire mode and opens a frame.
    always @(negedge i_sel_w) if (i_rstn) begin
        spi = 1;
        bn = 0;
        nb = 0;
        rd = 0;
    end
    // Select high turns the output to the inverse of its last bit; an unfinished byte is dropped.
    always @(posedge i_sel_w) drv = 0;
    // Four-wire input bits are taken on the rising clock edge.
    always @(posedge i_clk_w) if (spi && !i_sel_w) begin
        sh = {sh[6:0], i_dat_w};
        bn = bn + 1;
        if (bn == 8) begin
            bn = 0;
            if (nb == 0) begin
                ok = sh[7:1] == 7'h10;
                rd = sh[0] & ok;
            end else if (ok && !rd && nb == 1) ptr = sh[6:0];
            else if (ok && !rd) begin
                wr(ptr, sh);
                ptr++;
            end
            nb++;
        end
    end
    // Read data leaves on falling edges, most significant bit first.
    always @(negedge i_clk_w) if (spi && !i_sel_w && rd) begin
        if (bn == 0) begin
            tsh = mem[ptr];
            if (ptr == 12) mem[ptr] = 0;
            ptr++;
        end
        drv = 1;
        last = tsh[3'd7 - bn[2:0]];
    end
    assign o_dout = drv ? last : ~last;
    // Start and stop are data edges while the clock is high.
    always @(negedge i_dat_w) if (i_clk_w && !spi && i_rstn) begin
        on = 1;
        skip = 1;
        bn = 0;
        nb = 0;
        tx = 0;
    end
    always @(posedge i_dat_w) if (i_clk_w) begin
        on = 0;
        o_pull = 0;
    end
    // Two-wire bits sampled with clock high; a refusal ends a read.
    always @(posedge i_clk_w) if (on && !spi) begin
        if (bn < 8) sh = {sh[6:0], i_dat_w};
        else if (tx && i_dat_w) on = 0;
    end
    // The clock falling moves to the next bit and sets what this end drives.
    always @(negedge i_clk_w) if (on && !spi) begin
        if (skip) skip = 0;
        else if (bn == 7) begin
            bn = 8;
            o_pull = !tx;
            if (!tx && nb == 0) begin
                rd = sh[0];
                if (sh[7:1] != {4'h2, strap_q}) begin
                    on = 0;
                    o_pull = 0;
                end
            end else if (!tx && nb == 1) ptr = sh[6:0];
            else if (!tx) begin
                wr(ptr, sh);
                ptr++;
            end
        end else if (bn == 8) begin
            bn = 0;
            nb++;
            o_pull = 0;
            if (rd) begin
                tx = 1;
                tsh = mem[ptr];
                if (ptr == 12) mem[ptr] = 0;
                ptr++;
                o_pull = !tsh[7];
            end
        end else begin
            bn++;
            if (tx) o_pull = !tsh[3'd7 - bn[2:0]];
        end
    end
endmodule // dscp_dev_model
`default_nettype wire

// ==== verification/dscp_host_bench.sv ====
/* Self-checking bench for dscp_host with the device model on its pins.
   Assumes a 10 MHz core clock and pull-ups on the shared lines. */
`timescale 1ns/100ps
`default_nettype none
module dscp_host_bench;
    logic clk, rstn, use_i2c, valid, wr;
    logic [2:0] hstrap, dstrap, len;
    logic [6:0] rsel;
    logic [7:0] wdat;
    wire ready, rdv, rlast, done, nack, ck_o, ck_oe, d_o, d_oe, sel_o, sel_oe, pull, dout;
    wire [7:0] rdat;
    // Wire levels resolved from every party's enables.
    wire ck_w = ck_oe ? ck_o : 1'b1;
    wire d_w = (d_oe ? d_o : 1'b1) & ~pull;
    wire sel_w = sel_oe ? sel_o : dstrap[0];
    int n_fail, cmp_count, nrd;
    logic [7:0] got [0:7];
    logic got_last;

    dscp_host DUT (.i_core_clk(clk), .i_rstn(rstn), .i_use_i2c(use_i2c), .i_i2c_strap(hstrap),
        .i_cmd_valid(valid), .i_cmd_write(wr), .i_cmd_reg(rsel), .i_cmd_wdata(wdat),
        .i_cmd_len(len), .o_cmd_ready(ready), .o_rd_valid(rdv), .o_rd_data(rdat),
        .o_rd_last(rlast), .o_done(done), .o_nack(nack), .o_ctrl_bit_clock_out(ck_o),
        .o_ctrl_bit_clock_oe(ck_oe), .i_ctrl_serial_in_in(d_w), .o_ctrl_serial_in_out(d_o),
        .o_ctrl_serial_in_oe(d_oe), .i_ctrl_serial_out(dout),
        .o_addr0_or_select_pin_out(sel_o), .o_addr0_or_select_pin_oe(sel_oe));
    dscp_dev_model u_dev (.i_rstn(rstn), .i_strap(dstrap), .i_clk_w(ck_w), .i_dat_w(d_w),
        .i_sel_w(sel_w), .o_pull(pull), .o_dout(dout));

    // Core clock of 100 ns.
    initial begin
        clk = 0;
        forever #50 clk = ~clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tmo(input string what);
        n_fail++;
        $display("unexpected %s: expected 1, seen timeout", what);
        wrap_up();
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] act);
        cmp_count++;
        if (act !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, act);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic act);
        cmp_count++;
        if (act !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %b, seen %b", what, exp, act);
        end
    endtask
    // Expected register contents of the model's map.
    function automatic logic [7:0] ev(input logic [6:0] a);
        return 8'h5a ^ {1'b0, a};
    endfunction
    task automatic do_reset(input logic i2c, input logic [2:0] hs, input logic [2:0] ds);
        @(posedge clk);
        #1 rstn = 0;
        use_i2c = i2c;
        hstrap = hs;
        dstrap = ds;
        repeat (12) @(posedge clk);
        #1 rstn = 1;
    endtask
    // Offers one command and gathers read bytes until done, all bounded.
    task automatic run_cmd(input logic w, input logic [6:0] r, input logic [7:0] d,
        input logic [2:0] n);
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        if (k == 100) tmo("ready");
        @(posedge clk);
        #1 {valid, wr, rsel, wdat, len} = {1'b1, w, r, d, n};
        @(posedge clk);
        #1 valid = 0;
        nrd = 0;
        for (k = 0; k < 20000; k++) begin
            @(negedge clk);
            if (rdv === 1'b1 && nrd < 8) begin
                got[nrd] = rdat;
                got_last = rlast;
                nrd++;
            end
            if (done === 1'b1) break;
        end
        if (k == 20000) tmo("done");
    endtask
    // Burst read compared byte by byte against the map.
    task automatic read_span(input logic [6:0] r, input logic [2:0] n);
        run_cmd(0, r, 8'h00, n);
        chk1("nack", 1'b0, nack);
        chk8("byte count", 8'(n) + 8'h01, 8'(nrd));
        for (int i = 0; i <= int'(n); i++) begin
            chk8("read byte", ev(r + 7'(i)), got[i]);
        end
        chk1("last flag", 1'b1, got_last);
    endtask
    task automatic t_spi_write;
        run_cmd(1, 7'h05, 8'ha5, 3'h0);
        run_cmd(0, 7'h05, 8'h00, 3'h0);
        chk8("four-wire readback", 8'ha5, got[0]);
        $display("test spi_write done");
    endtask
    task automatic t_spi_span;
        run_cmd(1, 7'h1e, 8'h00, 3'h0);
        read_span(7'h1e, 3'h0);
        read_span(7'h19, 3'h7);
        $display("test spi_span done");
    endtask
    task automatic t_i2c_reads;
        read_span(7'h0e, 3'h7);
        read_span(7'h16, 3'h1);
        read_span(7'h0a, 3'h0);
        read_span(7'h0c, 3'h0);
        run_cmd(0, 7'h0c, 8'h00, 3'h0);
        chk8("cleared", 8'h00, got[0]);
        $display("test i2c_reads done");
    endtask
    task automatic t_i2c_write;
        run_cmd(1, 7'h02, 8'h3c, 3'h0);
        chk1("write nack", 1'b0, nack);
        run_cmd(0, 7'h02, 8'h00, 3'h0);
        chk8("two-wire readback", 8'h3c, got[0]);
        $display("test i2c_write done");
    endtask
    task automatic t_i2c_bad_addr;
        do_reset(1, 3'b100, 3'b101);
        run_cmd(0, 7'h19, 8'h00, 3'h0);
        chk1("refused address", 1'b1, nack);
        chk8("bytes after refusal", 8'h00, 8'(nrd));
        $display("test i2c_bad_addr done");
    endtask

    initial begin
        {rstn, valid, wr, len, rsel, wdat} = '0;
        n_fail = 0;
        cmp_count = 0;
        do_reset(0, 3'b000, 3'b000);
        t_spi_write();
        t_spi_span();
        do_reset(1, 3'b101, 3'b101);
        dstrap = 3'b011;
        t_i2c_reads();
        t_i2c_write();
        t_i2c_bad_addr();
        wrap_up();
    end
endmodule // dscp_host_bench
`default_nettype wire
